/* File: core/persist_defines.svh */
// Offsets, command codes, field positions, reset values and timing counts
// for the fault status and parameter persistence block.
// Assumes inclusion by bare name from files that need these numbers.
`ifndef PERSIST_DEFINES_SVH
`define PERSIST_DEFINES_SVH

// Object indexes and sub-indexes
`define IDX_FAULT_STATUS 16'h1002
`define IDX_STORE 16'h1010
`define IDX_RESTORE 16'h1011
`define SUB_LENGTH 8'h00
`define SUB_FIRST 8'h01
`define OBJ_LENGTH 32'h0000_0001

// Command codes, first character in the lowest byte
`define CODE_SAVE 32'h6576_6173
`define CODE_BKUP 32'h7075_6B62
`define CODE_FACT 32'h7463_6166
`define CODE_LOAD 32'h6461_6F6C
`define CODE_NORM 32'h6D72_6F6E
`define CODE_HOUR 32'h7275_6F68

// Storage mode values and field bits
`define MODE_NO_SAVE 2'h0
`define MODE_ON_COMMAND 2'h1
`define MODE_AUTO 2'h2
`define MODE_BOTH 2'h3
`define MODE_AUTO_BIT 1
`define MODE_MAX 32'h0000_0003

// Restore source read-back values
`define SRC_FACTORY 2'h0
`define SRC_BACKUP 2'h1
`define SRC_NORMAL 2'h2

// Fault word field positions
`define F1_DRIVER_LSB 12
`define F1_COIL_LSB 21
`define F1_PDO_TIMEOUT 30
`define F1_CAN 31
`define F2_CAN 0
`define F2_OVERCURRENT 1
`define F2_NODE_SRC 2
`define NUM_DRIVERS 9

// Reset values
`define RST_SAVE_MODE 2'h1
`define RST_RESTORE_SRC 2'h2

// Non-volatile write timeout
`define CLK_MHZ 200
`define NVM_TIMEOUT_US 10000
`define NVM_TIMEOUT_CYC (`NVM_TIMEOUT_US * `CLK_MHZ)

`endif

/* File: core/persist_pkg.sv */
// Types shared by the persistence block and its memory sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package persist_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_STORE_NORMAL,
    OP_STORE_BACKUP,
    OP_SAVE_MODE,
    OP_SAVE_RESTORE,
    OP_AUTO_SAVE,
    OP_BOOT_LOAD
  } nvm_op_e;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_BOOT_LOAD,
    ST_BOOT_COPY,
    ST_IDLE,
    ST_JOB,
    ST_AUTO
  } ctl_state_e;

endpackage

/* File: core/nvm_job_if.sv */
// Job hand-off between the command interpreter and the memory sequencer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface nvm_job_if;
  import persist_pkg::*;
  logic start;
  nvm_op_e op;
  logic [31:0] arg;
  logic done;
  logic fail;
  modport ctl (output start, output op, output arg, input done, input fail);
  modport seq (input start, input op, input arg, output done, output fail);
endinterface

/* File: core/nvm_sequencer.sv */
// Runs one non-volatile memory job on the external memory port.
// Assumes the memory controller answers each command with ack or err.
`timescale 1ns/1ps
`include "persist_defines.svh"
module nvm_sequencer import persist_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = `NVM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Job from the interpreter
  nvm_job_if.seq job,
  // Memory controller port
  output logic nvm_cmd_valid,
  output nvm_op_e nvm_cmd_op,
  output logic [31:0] nvm_cmd_arg,
  input wire logic nvm_ack,
  input wire logic nvm_err
);

  logic busy_r;
  logic [31:0] tmo_r;
  logic done_r;
  logic fail_r;
  nvm_op_e op_r;
  logic [31:0] arg_r;

  // A silent controller counts as a failed write, so the master gets an abort
  wire timed_out = busy_r && (tmo_r == TIMEOUT_CYC - 1);
  wire finish = busy_r && (nvm_ack || nvm_err || timed_out);
  wire failed = busy_r && (nvm_err || (timed_out && !nvm_ack));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      tmo_r <= 32'h0000_0000;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      op_r <= OP_NONE;
      arg_r <= 32'h0000_0000;
    end else begin
      done_r <= finish;
      fail_r <= failed;
      if (job.start && !busy_r) begin
        busy_r <= 1'b1;
        op_r <= job.op;
        arg_r <= job.arg;
        tmo_r <= 32'h0000_0000;
      end else if (finish) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        tmo_r <= tmo_r + 32'h0000_0001;
      end
    end
  end

  assign job.done = done_r;
  assign job.fail = fail_r;
  assign nvm_cmd_valid = busy_r;
  assign nvm_cmd_op = op_r;
  assign nvm_cmd_arg = arg_r;

endmodule

/* File: core/fault_status_param_persistence.sv */
// Fault status words and parameter persistence objects behind SDO access.
// Assumes an SDO layer presenting one decoded request at a time, and an
// external memory controller that moves parameter images on command.
//
// Overview of operation
// - Each present fault has its own bit
// - Word one bits 0-11 general faults
// - Word one bits 12-20 driver faults
// - Bits 21-29 coil, 30 timeout, 31 CAN
// - Word two: CAN, overcurrent, node source
// - Store sub-index reads and writes storage mode
// - Storage mode itself is always persisted
// - Mode 0 none, 1 command, 2 auto, 3 both
// - Save code stores RAM to normal area
// - Backup code stores RAM regardless of mode
// - Least significant byte travels first
// - Confirm after store completes, abort on failure
// - Bad store code: no store, abort
// - Normal writes never touch backup area
// - Restore code records source for next reset
// - Factory 0, backup 1, normal 2 codes
// - Backup restore also overwrites normal area
// - Restore: update, confirm; bad code aborts unchanged
// - Hour code presets hours, clears minutes
// - Fault words read-only at index 0x1002
// - Store object supports sub-index 1, length read at 0
// - Restore object at 0x1011 sub-index 1
`timescale 1ns/1ps
`include "persist_defines.svh"
module fault_status_param_persistence import persist_pkg::*; #(
  parameter int unsigned NVM_TIMEOUT_CYC = `NVM_TIMEOUT_CYC,
  parameter int unsigned HOUR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // SDO request, data byte 0 in bits 7:0
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0] req_sub,
  input wire logic [31:0] req_data,
  // SDO answer
  output logic req_busy,
  output logic rsp_valid,
  output logic rsp_abort,
  output logic [31:0] rsp_data,
  // Fault sources, levels
  input wire logic [11:0] general_fault,
  input wire logic [`NUM_DRIVERS-1:0] driver_fault,
  input wire logic [`NUM_DRIVERS-1:0] coil_fault,
  input wire logic pdo_timeout,
  input wire logic can_fault,
  input wire logic node_src_fault,
  // Values read from the persisted image at power-up
  input wire logic [1:0] boot_save_mode,
  input wire logic [1:0] boot_restore_src,
  // Parameter dictionary write event
  input wire logic param_write,
  // Hour meter
  input wire logic [HOUR_W-1:0] preset_hours,
  output logic hour_load,
  output logic [HOUR_W-1:0] hour_value,
  output logic minute_clear,
  // State shown to the rest of the module
  output logic [1:0] save_mode,
  output logic [1:0] restore_src,
  output logic boot_done,
  // Memory controller port
  output logic nvm_cmd_valid,
  output nvm_op_e nvm_cmd_op,
  output logic [31:0] nvm_cmd_arg,
  input wire logic nvm_ack,
  input wire logic nvm_err
);

  nvm_job_if job ();

  ctl_state_e st_r, st_nxt;
  logic [31:0] fault1_r;
  logic [31:0] fault2_r;
  logic [1:0] save_mode_r;
  logic [1:0] restore_src_r;
  logic [1:0] pend_val_r;
  logic pend_mode_r;
  logic pend_src_r;
  logic auto_pend_r;
  logic busy_r;
  logic rsp_valid_r;
  logic rsp_abort_r;
  logic [31:0] rsp_data_r;
  logic hour_load_r;
  logic [HOUR_W-1:0] hour_value_r;
  logic start_r;
  nvm_op_e op_r;
  logic [31:0] arg_r;
  logic boot_done_r;
  logic [1:0] boot_src_r;

  // Fault words; every fault present at once is visible
  wire [31:0] fault1_raw = {can_fault, pdo_timeout, coil_fault, driver_fault, general_fault};
  wire [31:0] fault2_raw = {29'h0000_0000, node_src_fault, general_fault[11], can_fault};

  // Request decode
  wire accept = req_valid && !busy_r;
  wire hit_fault = (req_index == `IDX_FAULT_STATUS) && (req_sub <= `SUB_FIRST);
  wire hit_store = (req_index == `IDX_STORE) && (req_sub == `SUB_FIRST);
  wire hit_rest = (req_index == `IDX_RESTORE) && (req_sub == `SUB_FIRST);
  wire hit_len = ((req_index == `IDX_STORE) || (req_index == `IDX_RESTORE)) && (req_sub == `SUB_LENGTH);
  wire rd_ok = hit_fault || hit_store || hit_rest || hit_len;

  // Exact 32-bit code compares, mode values 0 to 3 by range; a near miss is just an unknown code
  wire is_save = (req_data == `CODE_SAVE);
  wire is_bkup = (req_data == `CODE_BKUP);
  wire is_fact = (req_data == `CODE_FACT);
  wire is_load = (req_data == `CODE_LOAD);
  wire is_norm = (req_data == `CODE_NORM);
  wire is_hour = (req_data == `CODE_HOUR);
  wire is_mode = (req_data <= `MODE_MAX);

  wire wr_store = accept && req_write && hit_store;
  wire wr_rest = accept && req_write && hit_rest;
  wire store_ok = is_save || is_bkup || is_mode;
  wire rest_sel = is_fact || is_load || is_norm;
  wire bad_store = wr_store && !store_ok;
  wire bad_rest = wr_rest && !rest_sel && !is_hour;
  wire do_hour = wr_rest && is_hour;
  wire [1:0] rest_code = is_fact ? `SRC_FACTORY : (is_load ? `SRC_BACKUP : `SRC_NORMAL);

  wire [31:0] rd_data = hit_len ? `OBJ_LENGTH :
                        hit_store ? {30'h0000_0000, save_mode_r} :
                        hit_rest ? {30'h0000_0000, restore_src_r} :
                        (req_sub == `SUB_LENGTH) ? fault1_r : fault2_r;

  wire job_end = job.done;
  wire job_ok = job.done && !job.fail;
  wire auto_go = (st_r == ST_IDLE) && auto_pend_r && save_mode_r[`MODE_AUTO_BIT] && !accept;
  wire boot_backup = (boot_src_r == `SRC_BACKUP);

  // Controller sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_BOOT: st_nxt = ST_BOOT_LOAD;
      ST_BOOT_LOAD: if (job_end) st_nxt = (job_ok && boot_backup) ? ST_BOOT_COPY : ST_IDLE;
      ST_BOOT_COPY: if (job_end) st_nxt = ST_IDLE;
      ST_IDLE: begin
        if (accept && req_write && ((hit_store && store_ok) || (hit_rest && rest_sel))) st_nxt = ST_JOB;
        else if (auto_go) st_nxt = ST_AUTO;
      end
      ST_JOB: if (job_end) st_nxt = ST_IDLE;
      ST_AUTO: if (job_end) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Job launch selection
  wire launch_boot = (st_r == ST_BOOT);
  wire launch_copy = (st_r == ST_BOOT_LOAD) && job_ok && boot_backup;
  wire launch_sdo = (st_r == ST_IDLE) && (st_nxt == ST_JOB);
  wire launch = launch_boot || launch_copy || launch_sdo || auto_go;
  wire nvm_op_e sdo_op = !hit_store ? OP_SAVE_RESTORE :
                         is_save ? OP_STORE_NORMAL :
                         is_bkup ? OP_STORE_BACKUP : OP_SAVE_MODE;
  wire nvm_op_e launch_op = launch_boot ? OP_BOOT_LOAD :
                            launch_copy ? OP_STORE_NORMAL :
                            launch_sdo ? sdo_op : OP_AUTO_SAVE;
  // Straps read directly; the held copy only lands on this same edge
  wire [31:0] launch_arg = launch_boot ? {30'h0000_0000, boot_restore_src} :
                           (launch_sdo && hit_store && is_mode) ? req_data :
                           (launch_sdo && hit_rest) ? {30'h0000_0000, rest_code} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ST_BOOT;
      fault1_r <= 32'h0000_0000;
      fault2_r <= 32'h0000_0000;
      start_r <= 1'b0;
      op_r <= OP_NONE;
      arg_r <= 32'h0000_0000;
      boot_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fault1_r <= fault1_raw;
      fault2_r <= fault2_raw;
      start_r <= launch;
      op_r <= launch ? launch_op : op_r;
      arg_r <= launch ? launch_arg : arg_r;
      boot_done_r <= boot_done_r || (st_nxt == ST_IDLE);
    end
  end

  // Persisted settings are taken after reset release, never during it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      save_mode_r <= `RST_SAVE_MODE;
      restore_src_r <= `RST_RESTORE_SRC;
      boot_src_r <= `RST_RESTORE_SRC;
    end else if (st_r == ST_BOOT) begin
      save_mode_r <= boot_save_mode;
      restore_src_r <= boot_restore_src;
      boot_src_r <= boot_restore_src;
    end else if ((st_r == ST_JOB) && job_ok) begin
      if (pend_mode_r) save_mode_r <= pend_val_r;
      if (pend_src_r) restore_src_r <= pend_val_r;
    end
  end

  // Pending settings apply only once the memory write succeeded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_mode_r <= 1'b0;
      pend_src_r <= 1'b0;
      pend_val_r <= 2'h0;
    end else if (launch_sdo) begin
      pend_mode_r <= hit_store && is_mode && !is_save && !is_bkup;
      pend_src_r <= hit_rest;
      pend_val_r <= hit_rest ? rest_code : req_data[1:0];
    end
  end

  // Auto-save request; a new write in the launch cycle keeps it pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_pend_r <= 1'b0;
    end else if (param_write && save_mode_r[`MODE_AUTO_BIT]) begin
      auto_pend_r <= 1'b1;
    end else if (auto_go || !save_mode_r[`MODE_AUTO_BIT]) begin
      auto_pend_r <= 1'b0;
    end
  end

  // Answer path
  wire sdo_end = (st_r == ST_JOB) && job_end;
  wire rd_req = accept && !req_write;
  wire imm_rsp = rd_req || bad_store || bad_rest || do_hour || (accept && req_write && !hit_store && !hit_rest);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_abort_r <= 1'b0;
      rsp_data_r <= 32'h0000_0000;
    end else begin
      busy_r <= (st_nxt != ST_IDLE) || launch_sdo || imm_rsp || auto_go;
      rsp_valid_r <= imm_rsp || sdo_end;
      rsp_abort_r <= sdo_end ? job.fail :
                     rd_req ? !rd_ok : !do_hour;
      rsp_data_r <= (rd_req && rd_ok) ? rd_data : 32'h0000_0000;
    end
  end

  // Hour meter preset; minutes always restart at zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hour_load_r <= 1'b0;
      hour_value_r <= '0;
    end else begin
      hour_load_r <= do_hour;
      hour_value_r <= do_hour ? preset_hours : hour_value_r;
    end
  end

  assign job.start = start_r;
  assign job.op = op_r;
  assign job.arg = arg_r;

  nvm_sequencer #(.TIMEOUT_CYC(NVM_TIMEOUT_CYC)) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .job(job),
    .nvm_cmd_valid(nvm_cmd_valid),
    .nvm_cmd_op(nvm_cmd_op),
    .nvm_cmd_arg(nvm_cmd_arg),
    .nvm_ack(nvm_ack),
    .nvm_err(nvm_err)
  );

  assign req_busy = busy_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_abort = rsp_abort_r;
  assign rsp_data = rsp_data_r;
  assign hour_load = hour_load_r;
  assign minute_clear = hour_load_r;
  assign hour_value = hour_value_r;
  assign save_mode = save_mode_r;
  assign restore_src = restore_src_r;
  assign boot_done = boot_done_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fault_map_a: assert property (fault1_r == $past(fault1_raw) && fault1_r[4] == $past(general_fault[4]))
    else $error("fault word one mismatch");
  fault_two_a: assert property (fault2_r[31:3] == 29'h0 && fault2_r[0] == $past(can_fault))
    else $error("fault word two mismatch");
  mode_read_a: assert property (rd_req && hit_store |=> rsp_valid && rsp_data == {30'h0, $past(save_mode_r)})
    else $error("storage mode read wrong");
  bad_store_a: assert property (bad_store |=> rsp_valid && rsp_abort && !job.start)
    else $error("bad store code not aborted");
  store_done_a: assert property (st_r == ST_JOB && job_ok |=> rsp_valid && !rsp_abort)
    else $error("store not confirmed");
  store_fail_a: assert property (st_r == ST_JOB && job.done && job.fail |=> rsp_valid && rsp_abort)
    else $error("failed job not aborted");
  backup_go_a: assert property (wr_store && is_bkup |=> job.start && job.op == OP_STORE_BACKUP)
    else $error("backup store not launched");
  rest_keep_a: assert property (bad_rest |=> $stable(restore_src_r) ##1 $stable(restore_src_r))
    else $error("restore flag changed on bad code");
  hour_set_a: assert property (do_hour |=> hour_load && minute_clear && hour_value == $past(preset_hours))
    else $error("hour preset wrong");
  auto_gate_a: assert property (job.start && job.op == OP_AUTO_SAVE |-> save_mode_r[`MODE_AUTO_BIT])
    else $error("auto save in wrong mode");
  boot_copy_a: assert property (launch_copy |=> job.start && job.op == OP_STORE_NORMAL)
    else $error("backup restore did not copy");
  // Command and boot launches, hour preset, rejected writes and reads
  boot_arg_a: assert property (st_r == ST_BOOT |=> job.start && job.op == OP_BOOT_LOAD && job.arg == {30'h0000_0000, boot_src_r})
    else $error("boot load source wrong");
  save_norm_a: assert property (wr_store && is_save |=> job.start && job.op == OP_STORE_NORMAL)
    else $error("save code not launched");
  mode_save_a: assert property (wr_store && is_mode |=> job.start && job.op == OP_SAVE_MODE && job.arg == $past(req_data))
    else $error("storage mode not persisted");
  backup_only_a: assert property (job.start && job.op == OP_STORE_BACKUP |-> $past(wr_store && is_bkup))
    else $error("backup area written without backup code");
  bad_rest_a: assert property (bad_rest |=> rsp_valid && rsp_abort && !job.start)
    else $error("bad restore code not aborted");
  rest_rec_a: assert property (wr_rest && rest_sel |=> job.start && job.op == OP_SAVE_RESTORE && $stable(restore_src_r))
    else $error("restore code not recorded");
  hour_nojob_a: assert property (do_hour |=> rsp_valid && !rsp_abort && !job.start)
    else $error("hour preset not confirmed");
  len_read_a: assert property (rd_req && hit_len |=> rsp_valid && !rsp_abort && rsp_data == 32'h0000_0001)
    else $error("object length read wrong");
  ro_fault_a: assert property (accept && req_write && hit_fault |=> rsp_valid && rsp_abort)
    else $error("fault word write not aborted");

  store_ok_c: cover property (st_r == ST_JOB && job_ok);
  bad_code_c: cover property (bad_store);
  auto_save_c: cover property (job.start && job.op == OP_AUTO_SAVE);
  hour_c: cover property (do_hour);
  boot_copy_c: cover property (launch_copy);

endmodule

/* File: tb/nvm_model.sv */
// Memory controller stand-in for the persistence block.
// Assumes one job at a time, answered after a bench-set delay.
`timescale 1ns/1ps
module nvm_model import persist_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Job port
  input wire logic nvm_cmd_valid,
  input nvm_op_e nvm_cmd_op,
  input wire logic [31:0] nvm_cmd_arg,
  output logic nvm_ack,
  output logic nvm_err,
  // Bench control and job record
  input wire logic [7:0] delay,
  input wire logic fail_next,
  output nvm_op_e last_op,
  output logic [31:0] last_arg,
  output int jobs
);
  logic [7:0] cnt_r;
  logic done_r;

  // One answer per job; done_r blocks a second pulse while valid falls
  always @(posedge clk) begin
    if (!rst_n) begin
      nvm_ack <= 1'b0;
      nvm_err <= 1'b0;
      cnt_r <= 8'h00;
      done_r <= 1'b0;
      jobs <= 0;
      last_op <= OP_NONE;
      last_arg <= 32'h0000_0000;
    end else begin
      nvm_ack <= 1'b0;
      nvm_err <= 1'b0;
      if (!nvm_cmd_valid) begin
        cnt_r <= 8'h00;
        done_r <= 1'b0;
      end else if (!done_r) begin
        if (cnt_r == delay) begin
          nvm_ack <= !fail_next;
          nvm_err <= fail_next;
          done_r <= 1'b1;
          jobs <= jobs + 1;
          last_op <= nvm_cmd_op;
          last_arg <= nvm_cmd_arg;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the fault status and persistence block.
// Assumes the memory controller model and the design's defines header.
`timescale 1ns/1ps
`include "persist_defines.svh"
module tb_top import persist_pkg::*; ();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [15:0] req_index = 16'h0000;
  logic [7:0] req_sub = 8'h00;
  logic [31:0] req_data = 32'h0000_0000;
  logic req_busy, rsp_valid, rsp_abort, boot_done;
  logic [31:0] rsp_data;
  logic [31:0] fv = 32'h0000_0000;
  logic nf = 1'b0;
  logic [1:0] bmode = 2'h2;
  logic [1:0] bsrc = 2'h2;
  logic param_write = 1'b0;
  logic [15:0] preset_hours = 16'h0000;
  logic hour_load, minute_clear, mc;
  logic [15:0] hour_value, hv;
  logic [1:0] save_mode, restore_src;
  logic nvm_cmd_valid, nvm_ack, nvm_err;
  nvm_op_e nvm_cmd_op, last_op;
  logic [31:0] nvm_cmd_arg, last_arg;
  logic [7:0] delay = 8'h03;
  logic fail_next = 1'b0;
  int jobs;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int hour_seen = 0;

  always #2.5 clk = ~clk;

  fault_status_param_persistence #(.NVM_TIMEOUT_CYC(20), .HOUR_W(16)) i_fault_status_param_persistence (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
    .req_sub(req_sub), .req_data(req_data), .req_busy(req_busy), .rsp_valid(rsp_valid),
    .rsp_abort(rsp_abort), .rsp_data(rsp_data), .general_fault(fv[11:0]), .driver_fault(fv[20:12]),
    .coil_fault(fv[29:21]), .pdo_timeout(fv[30]), .can_fault(fv[31]), .node_src_fault(nf),
    .boot_save_mode(bmode), .boot_restore_src(bsrc), .param_write(param_write),
    .preset_hours(preset_hours), .hour_load(hour_load), .hour_value(hour_value),
    .minute_clear(minute_clear), .save_mode(save_mode), .restore_src(restore_src),
    .boot_done(boot_done), .nvm_cmd_valid(nvm_cmd_valid), .nvm_cmd_op(nvm_cmd_op),
    .nvm_cmd_arg(nvm_cmd_arg), .nvm_ack(nvm_ack), .nvm_err(nvm_err));

  nvm_model i_nvm_model (
    .clk(clk), .rst_n(rst_n), .nvm_cmd_valid(nvm_cmd_valid), .nvm_cmd_op(nvm_cmd_op),
    .nvm_cmd_arg(nvm_cmd_arg), .nvm_ack(nvm_ack), .nvm_err(nvm_err), .delay(delay),
    .fail_next(fail_next), .last_op(last_op), .last_arg(last_arg), .jobs(jobs));

  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles; a hang stops at cycle 20000
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hour_load === 1'b1) begin
      hour_seen <= hour_seen + 1;
      hv <= hour_value;
      mc <= minute_clear;
    end
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until taken with busy low; answer read at the settled half cycle
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] dat,
                     input logic eab, input logic [31:0] erd);
    logic b;
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_index <= idx;
    req_sub <= sub;
    req_data <= dat;
    b = 1'b1;
    while (b !== 1'b0) begin
      @(negedge clk);
      b = req_busy;
      @(posedge clk);
    end
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    chk({30'h0, rsp_valid, rsp_abort}, {30'h0, 1'b1, eab});
    chk(rsp_data, erd);
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [1:0] s);
    int n;
    @(posedge clk);
    bmode <= m;
    bsrc <= s;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (boot_done !== 1'b1 && n < 200);
    chk({31'h0, boot_done}, 32'h1);
  endtask

  initial begin
    logic [31:0] v;
    logic [31:0] codes [3];
    int j;
    codes = '{`CODE_FACT, `CODE_LOAD, `CODE_NORM};
    do_reset(2'h2, 2'h2);
    chk(32'(last_op), 32'(OP_BOOT_LOAD));
    chk(last_arg, 32'h0000_0002);
    chk({30'h0, save_mode}, 32'h2);
    $display("test boot done");
    // Walking one, all set, then node source alone
    for (int i = 0; i < 34; i++) begin
      v = (i < 32) ? (32'h0000_0001 << i) : ((i == 32) ? 32'hFFFF_FFFF : 32'h0000_0000);
      @(posedge clk);
      fv <= v;
      nf <= (i >= 32);
      acc(1'b0, `IDX_FAULT_STATUS, 8'h00, 32'h0, 1'b0, v);
      acc(1'b0, `IDX_FAULT_STATUS, 8'h01, 32'h0, 1'b0, {29'h0, i >= 32, v[11], v[31]});
    end
    acc(1'b1, `IDX_FAULT_STATUS, 8'h00, 32'h1, 1'b1, 32'h0);
    acc(1'b0, 16'h1003, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b0, `IDX_STORE, 8'h02, 32'h0, 1'b1, 32'h0);
    acc(1'b0, `IDX_STORE, `SUB_LENGTH, 32'h0, 1'b0, `OBJ_LENGTH);
    acc(1'b0, `IDX_RESTORE, `SUB_LENGTH, 32'h0, 1'b0, `OBJ_LENGTH);
    acc(1'b1, `IDX_STORE, `SUB_LENGTH, 32'h1, 1'b1, 32'h0);
    $display("test faults done");
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, `IDX_STORE, `SUB_FIRST, 32'(m), 1'b0, 32'h0);
      chk(32'(last_op), 32'(OP_SAVE_MODE));
      chk(last_arg, 32'(m));
      acc(1'b0, `IDX_STORE, `SUB_FIRST, 32'h0, 1'b0, 32'(m));
      @(posedge clk);
      param_write <= 1'b1;
      @(posedge clk);
      param_write <= 1'b0;
      repeat (40) @(posedge clk);
      chk(32'(last_op), (m >= 2) ? 32'(OP_AUTO_SAVE) : 32'(OP_SAVE_MODE));
    end
    acc(1'b1, `IDX_STORE, `SUB_FIRST, 32'h0, 1'b0, 32'h0);
    acc(1'b1, `IDX_STORE, `SUB_FIRST, `CODE_BKUP, 1'b0, 32'h0);
    chk(32'(last_op), 32'(OP_STORE_BACKUP));
    acc(1'b1, `IDX_STORE, `SUB_FIRST, 32'h6576_6173, 1'b0, 32'h0);
    chk(32'(last_op), 32'(OP_STORE_NORMAL));
    @(posedge clk);
    fail_next <= 1'b1;
    acc(1'b1, `IDX_STORE, `SUB_FIRST, `CODE_SAVE, 1'b1, 32'h0);
    fail_next <= 1'b0;
    delay <= 8'h28;
    acc(1'b1, `IDX_STORE, `SUB_FIRST, `CODE_SAVE, 1'b1, 32'h0);
    delay <= 8'h03;
    j = jobs;
    // One wrong byte at each place, a mode out of range, a store code on restore
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `IDX_STORE, `SUB_FIRST, `CODE_SAVE ^ (32'h0000_0001 << (8 * i)), 1'b1, 32'h0);
    end
    acc(1'b1, `IDX_STORE, `SUB_FIRST, 32'h0000_0004, 1'b1, 32'h0);
    acc(1'b1, `IDX_RESTORE, `SUB_FIRST, `CODE_SAVE, 1'b1, 32'h0);
    chk(32'(jobs), 32'(j));
    $display("test store done");
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, `IDX_RESTORE, `SUB_FIRST, codes[i], 1'b0, 32'h0);
      chk(32'(last_op), 32'(OP_SAVE_RESTORE));
      chk(last_arg, 32'(i));
      acc(1'b0, `IDX_RESTORE, `SUB_FIRST, 32'h0, 1'b0, 32'(i));
      chk({30'h0, restore_src}, 32'(i));
    end
    @(posedge clk);
    fail_next <= 1'b1;
    acc(1'b1, `IDX_RESTORE, `SUB_FIRST, `CODE_FACT, 1'b1, 32'h0);
    fail_next <= 1'b0;
    acc(1'b1, `IDX_RESTORE, `SUB_FIRST, `CODE_NORM ^ 32'h0100_0000, 1'b1, 32'h0);
    acc(1'b0, `IDX_RESTORE, `SUB_FIRST, 32'h0, 1'b0, 32'h2);
    // Factory, then save, then keyswitch_power cycle
    acc(1'b1, `IDX_RESTORE, `SUB_FIRST, `CODE_FACT, 1'b0, 32'h0);
    acc(1'b1, `IDX_STORE, `SUB_FIRST, `CODE_SAVE, 1'b0, 32'h0);
    do_reset(2'h1, 2'h0);
    chk(last_arg, 32'h0);
    chk(32'(jobs), 32'h1);
    $display("test restore done");
    @(posedge clk);
    preset_hours <= 16'h1234;
    j = jobs;
    acc(1'b1, `IDX_RESTORE, `SUB_FIRST, `CODE_HOUR, 1'b0, 32'h0);
    @(negedge clk);
    chk(32'(hour_seen), 32'h1);
    chk({16'h0, hv}, 32'h0000_1234);
    chk({31'h0, mc}, 32'h1);
    chk(32'(jobs), 32'(j));
    // Boot from backup copies the image into the normal area as well
    do_reset(2'h1, 2'h1);
    chk(32'(last_op), 32'(OP_STORE_NORMAL));
    chk(32'(jobs), 32'h2);
    chk({30'h0, save_mode}, 32'h1);
    // Backup image carries the normal restore setting, so the next boot loads only
    do_reset(2'h1, 2'h2);
    chk(last_arg, 32'h0000_0002);
    chk(32'(jobs), 32'h1);
    chk({30'h0, restore_src}, 32'h2);
    $display("test hour and backup boot done");
    results();
  end
endmodule
